// [rtl/adc_seq_pkg.sv]
// constants for the converter scan sequencer
// assumes a 40 MHz system clock and an APB master with 32-bit data
// How it works
// [R1] software clears run bit before changing mode, group and count, then sets it
// [R2] scan converts selected channels ascending, each into its own result register
// [R3] after full pass set end flag, interrupt if enabled, restart at first channel
// [R4] scanning repeats while the run bit stays set
// [R5] clearing run bit discards current conversion; results keep last values
// [R6] setting run bit again always starts at the first selected channel
// [R7] first scan channel is input 0 for group 0, input 4 for group 1
// [R8] sync delay 18 to 33 states slow, 10 to 17 states fast
// [R9] sampling follows delay: 63 states slow, 31 fast; conversion after it
// [R10] single conversion totals 259 to 274 slow, 131 to 138 fast states
// [R11] later scan conversions take exactly 256 slow or 128 fast states
// [R12] trigger enabled: run bit set one clock after trigger is sampled
// [R13] transfer enable bit routes end interrupt to controller, which clears flag
// [R14] transfer controller moves one channel result per end interrupt
// [R15] end interrupt request gated by the interrupt enable bit
// [R16] only a falling trigger edge sets run bit, and only when enabled
// [R17] cpu clears end flag by reading status then writing zero
// [R18] single mode converts once, clears run bit, sets end flag
// [R19] group bit picks 0-3 or 4-7; low bits pick channel or count
// [R20] setting run bit while running does not restart the sequence
// [R21] durations counted in clock states by speed select, slow at reset
package adc_seq_pkg;
  localparam logic [11:0] CSR_OFF    = 12'h000;
  localparam logic [11:0] TRG_OFF    = 12'h004;
  localparam logic [11:0] XFER_OFF   = 12'h008;
  localparam logic [11:0] RES_OFF    = 12'h010; // eight result words, 4 apart
  localparam logic [11:0] SAMP_OFF   = 12'h030; // mapped slot for the current channel sample; reads zero
  localparam logic [11:0] XACK_OFF   = 12'h034; // controller completion strobe
  localparam int FLAG_BIT   = 7;
  localparam int IE_BIT     = 6;
  localparam int RUN_BIT    = 5;
  localparam int SCAN_BIT   = 4;
  localparam int SPEED_BIT  = 3;
  localparam int GROUP_BIT  = 2;
  localparam int EXTERNAL_TRIGGER_ENABLE_BIT   = 7;
  localparam int XFER_BIT   = 0;
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] TRG_RST = 8'h7F; // reserved bits read one
  localparam logic [8:0] SYNC_MIN_SLOW = 9'd18;
  localparam logic [8:0] SYNC_MIN_FAST = 9'd10;
  localparam logic [8:0] SYNC_SPAN_SLOW = 9'd16; // 18..33
  localparam logic [8:0] SYNC_SPAN_FAST = 9'd8;  // 10..17
  localparam logic [8:0] SAMP_SLOW = 9'd63;
  localparam logic [8:0] SAMP_FAST = 9'd31;
  localparam logic [8:0] CONV_SLOW = 9'd256; // sample plus approximation
  localparam logic [8:0] CONV_FAST = 9'd128;
  // first conversion after sampling: single-mode totals minus delay and sample
  localparam logic [8:0] FIRST_CONV_SLOW = 9'd178;
  localparam logic [8:0] FIRST_CONV_FAST = 9'd90;
  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_SAMPLE, ST_CONVERT} seq_state_t;
endpackage

// [rtl/adc_scan_sequencer.sv]
// converter scan sequencer with APB register slave
// assumes a synchronous trigger pin source and an analog value presented per channel
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module adc_scan_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        external_trigger_pin,
  input  wire logic [9:0]  analog_value,
  output logic [2:0]       channel_sel,
  output logic             sampling,
  output logic             conversion_end_interrupt,
  output logic             transfer_request
);
  logic [7:0]  csr_q;
  logic        external_trigger_enable_q;
  logic        xfer_en_q;
  logic        flag_read_q;
  logic [9:0]  result_q [8];
  seq_state_t  state_q;
  logic [8:0]  cnt_q;
  logic [8:0]  sync_lfsr_q;
  logic [2:0]  chan_q;
  logic        first_q;
  logic        trg_s1_q, trg_s2_q, trg_s3_q;
  logic        trig_set_q;
  logic [9:0]  samp_q;

  wire run      = csr_q[RUN_BIT];
  wire scan     = csr_q[SCAN_BIT];
  wire slow     = ~csr_q[SPEED_BIT];
  wire [2:0] first_ch = {csr_q[GROUP_BIT], csr_q[GROUP_BIT] ? 2'b00 : 2'b00}; // R7
  wire [2:0] last_ch  = {csr_q[GROUP_BIT], csr_q[1:0]};

  // address decode shared by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  wire rd    = acc & ~pwrite;
  wire rd_csr = rd & hit(paddr, CSR_OFF);
  wire wr_csr = wr & hit(paddr, CSR_OFF);
  wire mapped = hit(paddr, CSR_OFF) | hit(paddr, TRG_OFF) | hit(paddr, XFER_OFF) |
                (paddr >= RES_OFF && paddr < SAMP_OFF && paddr[1:0] == 2'b00) |
                hit(paddr, SAMP_OFF) | hit(paddr, XACK_OFF);

  // zero-wait-state slave: answer in access phase at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        if (hit(paddr, CSR_OFF)) prdata <= {24'h00_0000, csr_q};
        else if (hit(paddr, TRG_OFF)) prdata <= {24'h00_0000, external_trigger_enable_q, 7'h7F};
        else if (hit(paddr, XFER_OFF)) prdata <= {31'h0000_0000, xfer_en_q};
        else if (paddr >= RES_OFF && paddr < SAMP_OFF)
          prdata <= {16'h0000, result_q[3'(paddr[5:2] - 4'h4)], 6'h00};
      end
    end
  end

  // trigger pin two-flop sync plus edge stage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trg_s1_q <= 1'b1;
      trg_s2_q <= 1'b1;
      trg_s3_q <= 1'b1;
      trig_set_q <= 1'b0;
    end else begin
      trg_s1_q <= external_trigger_pin;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
      trig_set_q <= external_trigger_enable_q & trg_s3_q & ~trg_s2_q; // R16 R12
    end
  end

  // trigger enable and transfer enable registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      external_trigger_enable_q    <= TRG_RST[EXTERNAL_TRIGGER_ENABLE_BIT];
      xfer_en_q <= 1'b0;
      samp_q    <= 10'h000;
    end else begin
      samp_q <= analog_value;
      if (wr & hit(paddr, TRG_OFF) & pready) external_trigger_enable_q <= pwdata[EXTERNAL_TRIGGER_ENABLE_BIT];
      if (wr & hit(paddr, XFER_OFF) & pready) xfer_en_q <= pwdata[XFER_BIT]; // R13
    end
  end

  // remembers a status read with the flag set so a zero write may clear it
  always_ff @(posedge clk) begin
    if (sys_rst) flag_read_q <= 1'b0;
    else if (rd_csr & pready) flag_read_q <= csr_q[FLAG_BIT];
    else if (wr_csr & pready) flag_read_q <= 1'b0;
  end

  wire done = (state_q == ST_CONVERT) && cnt_q == 9'd1 && run;
  wire pass_end = done && (!scan || chan_q == last_ch);
  wire xack = wr & pready & hit(paddr, XACK_OFF);

  // control and status register; hardware sets win over software and transfer clears
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      csr_q <= CSR_RST; // R21
    end else begin
      if (wr_csr & pready) begin
        csr_q[6:0] <= pwdata[6:0]; // R1 R5
        if (!pwdata[FLAG_BIT] && flag_read_q) csr_q[FLAG_BIT] <= 1'b0; // R17
      end
      if (xack & xfer_en_q) csr_q[FLAG_BIT] <= 1'b0; // R13
      if (trig_set_q) csr_q[RUN_BIT] <= 1'b1; // R12
      if (pass_end && !scan) csr_q[RUN_BIT] <= 1'b0; // R18
      if (pass_end) csr_q[FLAG_BIT] <= 1'b1; // R3 R18
    end
  end

  // pseudo-random sync length emulates the write-to-cycle alignment
  always_ff @(posedge clk) begin
    if (sys_rst) sync_lfsr_q <= 9'h001;
    else sync_lfsr_q <= {sync_lfsr_q[7:0], sync_lfsr_q[8] ^ sync_lfsr_q[4]};
  end

  wire [8:0] sync_len = slow ? SYNC_MIN_SLOW + (sync_lfsr_q & (SYNC_SPAN_SLOW - 9'd1))
                             : SYNC_MIN_FAST + (sync_lfsr_q & (SYNC_SPAN_FAST - 9'd1));
  wire [8:0] samp_len = slow ? SAMP_SLOW : SAMP_FAST;
  wire [8:0] conv_len = (slow ? CONV_SLOW : CONV_FAST) - samp_len;
  // first conversion is shorter so delay, sample and convert fit the single range
  wire [8:0] first_len = slow ? FIRST_CONV_SLOW : FIRST_CONV_FAST;

  // sequencer: sync, sample, convert, then next channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= 9'd0;
      chan_q  <= 3'd0;
      first_q <= 1'b0;
    end else if (!run) begin
      state_q <= ST_IDLE; // R5 R6
      cnt_q   <= 9'd0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_SYNC; // R6 R20
          chan_q  <= scan ? first_ch : last_ch; // R7 R19
          cnt_q   <= sync_len; // R8
          first_q <= 1'b1;
        end
        ST_SYNC: begin
          if (cnt_q <= 9'd2) begin // idle cycle counts as the first delay state
            state_q <= ST_SAMPLE;
            cnt_q   <= samp_len; // R9
          end else cnt_q <= cnt_q - 9'd1;
        end
        ST_SAMPLE: begin
          if (cnt_q == 9'd1) begin
            state_q <= ST_CONVERT;
            cnt_q   <= first_q ? first_len : conv_len; // R10 R11
          end else cnt_q <= cnt_q - 9'd1;
        end
        ST_CONVERT: begin
          if (cnt_q == 9'd1) begin
            first_q <= 1'b0;
            if (scan) begin
              state_q <= ST_SAMPLE; // R4 R11
              cnt_q   <= samp_len;
              chan_q  <= (chan_q == last_ch) ? first_ch : chan_q + 3'd1; // R2 R3
            end else begin
              state_q <= ST_IDLE;
              cnt_q   <= 9'd0;
            end
          end else cnt_q <= cnt_q - 9'd1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // results land only on completion; discarded work leaves them untouched
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_res
      always_ff @(posedge clk) begin
        if (sys_rst) result_q[gi] <= 10'h000;
        else if (done && chan_q == 3'(gi)) result_q[gi] <= samp_q; // R2 R5
      end
    end
  endgenerate

  // outward strobes and status, one request per pass
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      channel_sel              <= 3'd0;
      sampling                 <= 1'b0;
      conversion_end_interrupt <= 1'b0;
      transfer_request         <= 1'b0;
    end else begin
      channel_sel <= chan_q;
      sampling    <= run && state_q == ST_SAMPLE;
      conversion_end_interrupt <= csr_q[FLAG_BIT] & csr_q[IE_BIT] & ~xfer_en_q; // R15
      transfer_request <= pass_end & csr_q[IE_BIT] & xfer_en_q; // R13 R14
    end
  end

  // slow scan: after the first conversion each next sample starts at the full length
  property later_len_p;
    @(posedge clk) disable iff (sys_rst)
      (state_q == ST_CONVERT && cnt_q == 9'd1 && run && scan && slow)
      |=> (state_q == ST_SAMPLE && cnt_q == SAMP_SLOW);
  endproperty
  scan_len_a: assert property (later_len_p) else $error("scan timing wrong"); // R11

  sync_range_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
    (state_q == ST_IDLE && run) |=> (slow ? (cnt_q >= 9'd18 && cnt_q <= 9'd33)
                                           : (cnt_q >= 9'd10 && cnt_q <= 9'd17)))
    else $error("sync delay out of range");

  samp_len_a: assert property (@(posedge clk) disable iff (sys_rst) // R9
    (state_q == ST_SYNC && cnt_q <= 9'd2 && run) |=> cnt_q == (slow ? 9'd63 : 9'd31))
    else $error("sampling length wrong");

  single_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // R18
    (pass_end && !scan) |=> !csr_q[RUN_BIT] && csr_q[FLAG_BIT])
    else $error("single mode did not stop");

  stop_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
    !run |=> state_q == ST_IDLE)
    else $error("sequence kept running");

  irq_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // R15
    !csr_q[IE_BIT] |=> !conversion_end_interrupt)
    else $error("interrupt not gated");

  restart_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
    (state_q == ST_IDLE && run && scan) |=> chan_q == first_ch)
    else $error("restart not at first channel");

  trig_a: assert property (@(posedge clk) disable iff (sys_rst) // R16
    (!external_trigger_enable_q && !(wr_csr & pready)) |=> !$rose(csr_q[RUN_BIT]))
    else $error("trigger acted while disabled");
endmodule // adc_scan_sequencer

// [verif/analog_source.sv]
// far-side model: analog inputs of eight channels and the trigger source
// assumes channel_sel comes from the sequencer; the trigger pin is pulled high
`timescale 1ns/100ps
module analog_source (
  input  wire logic       clk,
  input  wire logic [2:0] channel_sel,
  input  wire logic       fire,
  output logic [9:0]      analog_value,
  output logic            external_trigger_pin
);
  logic [2:0] low_q = 3'h0;
  // each channel shows its own code, so a misrouted result cannot pass
  assign analog_value = {channel_sel, 4'hA, channel_sel};
  // one fire gives a four-cycle low pulse, so exactly one falling edge
  always_ff @(posedge clk) begin
    if (fire) begin
      low_q <= 3'h4;
    end else if (low_q != 3'h0) begin
      low_q <= low_q - 3'h1;
    end
  end
  assign external_trigger_pin = (low_q == 3'h0);
endmodule // analog_source

// [verif/tb_adc_scan_sequencer.sv]
// self-checking bench for the converter scan sequencer
// assumes an APB slave that answers in the access cycle, one clock
`timescale 1ns/100ps
module tb_adc_scan_sequencer;
  import adc_seq_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        fire = 1'b0, pready, pslverr, sampling, irq, xreq, trig, err = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0]  ana;
  logic [2:0]  chs;
  int          n_errors = 0, checks = 0, cyc = 0, samp_n = 0, last_samp = 0, tr_n = 0;
  int          ch_q[$], rise_q[$];
  adc_scan_sequencer u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .external_trigger_pin(trig), .analog_value(ana), .channel_sel(chs),
    .sampling(sampling), .conversion_end_interrupt(irq), .transfer_request(xreq));
  analog_source u_src (.clk(clk), .channel_sel(chs), .fire(fire), .analog_value(ana),
    .external_trigger_pin(trig));
  always #12.5 clk = ~clk;
  // monitor: sampling run length, channel order, rise times, transfer pulses
  always @(posedge clk) begin
    cyc++;
    if (xreq === 1'b1) tr_n++;
    if (sampling === 1'b1) begin
      if (samp_n == 0) begin
        ch_q.push_back(chs);
        rise_q.push_back(cyc);
      end
      samp_n++;
    end else if (samp_n != 0) begin
      last_samp = samp_n;
      samp_n = 0;
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll the control word until the masked bits match, bounded
  task automatic wait_csr(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 800; i++) begin
      apb(1'b0, CSR_OFF, 32'h0);
      if ((rd & m) === v) return;
    end
    n_errors++;
    close_out();
  endtask
  function automatic logic [31:0] res(input logic [2:0] c);
    return {16'h0, c, 4'hA, c, 6'h00};
  endfunction
  task automatic t_reset();
    apb(1'b0, CSR_OFF, 32'h0);
    chk("csr reset", 32'h0, rd);
    apb(1'b0, TRG_OFF, 32'h0);
    chk("trg reset", 32'h7F, rd);
    apb(1'b0, 12'h03C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask
  task automatic t_scan();
    apb(1'b1, CSR_OFF, 32'h1E);
    ch_q.delete();
    rise_q.delete();
    apb(1'b1, CSR_OFF, 32'h3E);
    wait_csr(32'h80, 32'h80);
    for (int c = 4; c < 7; c++) begin
      apb(1'b0, RES_OFF + 12'(4 * c), 32'h0);
      chk("scan result", res(3'(c)), rd);
      chk("scan order", 32'(c), 32'(ch_q[c - 4]));
    end
    while (ch_q.size() < 5 && cyc < 90000) @(posedge clk);
    chk("rescan first", 32'h4, 32'(ch_q[3]));
    chk("later conv", 32'd128, 32'(rise_q[2] - rise_q[1]));
    chk("fast sample", 32'd31, 32'(last_samp));
    apb(1'b1, CSR_OFF, 32'h1E);
    apb(1'b0, CSR_OFF, 32'h0);
    chk("stopped", 32'h1E, rd);
    ch_q.delete();
    apb(1'b1, CSR_OFF, 32'h3E);
    apb(1'b1, CSR_OFF, 32'h3E);
    while (ch_q.size() < 2 && cyc < 90000) @(posedge clk);
    chk("restart first", 32'h4, 32'(ch_q[0]));
    apb(1'b1, CSR_OFF, 32'h1E);
    $display("test scan done");
  endtask
  task automatic t_single();
    apb(1'b1, CSR_OFF, 32'h41);
    apb(1'b1, CSR_OFF, 32'h61);
    wait_csr(32'h80, 32'h80);
    chk("single csr", 32'hC1, rd);
    chk("irq on", 32'h1, {31'h0, irq});
    chk("slow sample", 32'd63, 32'(last_samp));
    apb(1'b0, RES_OFF + 12'h004, 32'h0);
    chk("single result", res(3'h1), rd);
    apb(1'b1, CSR_OFF, 32'h01);
    repeat (2) @(posedge clk); // interrupt output is registered behind the flag
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test single done");
  endtask
  task automatic t_trigger();
    apb(1'b1, TRG_OFF, 32'h80);
    apb(1'b1, CSR_OFF, 32'h08);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_csr(32'h80, 32'h80);
    chk("trig start", 32'h88, rd);
    apb(1'b1, CSR_OFF, 32'h08);
    apb(1'b1, TRG_OFF, 32'h00);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b0, CSR_OFF, 32'h0);
    chk("trig off", 32'h08, rd);
    $display("test trigger done");
  endtask
  task automatic t_xfer();
    apb(1'b1, XFER_OFF, 32'h1);
    apb(1'b1, CSR_OFF, 32'h48);
    tr_n = 0;
    apb(1'b1, CSR_OFF, 32'h68);
    wait_csr(32'h20, 32'h00);
    chk("xfer pulses", 32'h1, 32'(tr_n));
    chk("cpu irq", 32'h0, {31'h0, irq});
    apb(1'b1, XACK_OFF, 32'h1);
    apb(1'b0, CSR_OFF, 32'h0);
    chk("xfer flag", 32'h48, rd);
    $display("test transfer done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_scan();
    t_single();
    t_trigger();
    t_xfer();
    close_out();
  end
endmodule // tb_adc_scan_sequencer
